/* File: rtl/abu_compare.sv */
// Sixteen-bit address comparator for the breakpoint unit.
`timescale 1ns/10ps
module abu_compare (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Compare link
    abu_match_if.cmp m
);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            m.hit <= 1'b0;
        end else begin
            m.hit <= (m.bus_addr == m.break_addr);
        end
    end

endmodule // abu_compare

/* File: rtl/abu_match_if.sv */
// Interface carrying the compare request and result between modules.
`timescale 1ns/10ps
interface abu_match_if;
    logic [15:0] bus_addr;
    logic [15:0] break_addr;
    logic hit;

    modport core (output bus_addr, output break_addr, input hit);
    modport cmp (input bus_addr, input break_addr, output hit);
endinterface

/* File: rtl/abu_pkg.sv */
// Package of register map, field positions and constants for the breakpoint unit.
package abu_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL_STATUS = 12'h000;
    localparam logic [11:0] OFS_ADDR_HIGH = 12'h004;
    localparam logic [11:0] OFS_ADDR_LOW = 12'h008;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
    localparam logic [11:0] OFS_MONITOR = 12'h014;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_BREAK = 1;
    localparam int IRQ_W = 2;

    // ------------------------------------------------------------------
    // Reset values and vectors
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
    localparam logic [7:0] RST_ADDR_BYTE = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
    localparam logic [15:0] VEC_NORMAL = 16'hFFFC;
    localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
    localparam logic [7:0] SWI_OPCODE = 8'h83;

    // ------------------------------------------------------------------
    // Break sequencer states (Gray along the usual path)
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ABU_IDLE = 2'b00,
        ABU_PEND = 2'b01,
        ABU_INJECT = 2'b11,
        ABU_SERVE = 2'b10
    } abu_state_t;

endpackage

/* File: rtl/abu_top.sv */
// Address breakpoint unit with APB register access and CPU break control.
`timescale 1ns/10ps

// How it works
// - A break is started by forcing the software interrupt opcode into the CPU instruction register.
// - The break vector is the normal pair, or the alternate pair in monitor mode.
// - A pending break waits until the running instruction has completed.
// - A match on the cycle just before the last cycle of an instruction starts the break at once.
// - The timer counter is frozen while a break is serviced.
// - The watchdog is disabled during a break while the test voltage is on the reset pin.
// - With break enable set a full 16-bit address match raises a break, otherwise none.
// - Break enable is bit 7 of the control register, cleared by writing zero or by reset.
// - The break active flag is set whenever the address of a bus cycle matches the break address.
// - Writing one to the break active flag forces a break as if a match had occurred.
// - Software clears the break active flag by writing zero before leaving; reset clears it.
module abu_top (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // CPU core
    input wire logic [15:0] cpu_addr_i,
    input wire logic bus_cycle_i,
    input wire logic instr_last_i,
    input wire logic vector_taken_i,
    input wire logic test_mode_voltage_i,
    output logic force_opcode_o,
    output logic [7:0] opcode_o,
    output logic [15:0] vector_o,
    // Peripheral controls
    output logic timer_freeze_o,
    output logic watchdog_disable_o,
    output logic break_busy_o,
    // Interrupt
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic enable_q;
    logic active_q;
    logic [7:0] addr_high_q;
    logic [7:0] addr_low_q;
    logic monitor_q;
    logic [abu_pkg::IRQ_W-1:0] irq_stat_q;
    logic [abu_pkg::IRQ_W-1:0] irq_mask_q;
    abu_pkg::abu_state_t state_q;
    abu_pkg::abu_state_t state_d;
    logic hit_ok;
    logic wr_acc;
    logic rd_acc;
    logic sw_force;
    logic start_now;
    logic [31:0] rdata_d;
    logic err_d;

    abu_match_if mif ();

    // ------------------------------------------------------------------
    // Address compare
    // ------------------------------------------------------------------
    assign mif.bus_addr = cpu_addr_i;
    assign mif.break_addr = {addr_high_q, addr_low_q};

    abu_compare u_cmp (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .m(mif.cmp)
    );

    // The compare result is registered, so a match seen here belongs to
    // the bus cycle one clock earlier; the pipeline keeps timing short.
    logic cycle_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cycle_q <= 1'b0;
        end else begin
            cycle_q <= bus_cycle_i;
        end
    end
    assign hit_ok = mif.hit & cycle_q;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    function automatic logic is_reg(input logic [11:0] a,
                                    input logic [11:0] ofs);
        is_reg = (a == ofs);
    endfunction

    function automatic logic known(input logic [11:0] a);
        known = is_reg(a, abu_pkg::OFS_CTRL_STATUS) |
                is_reg(a, abu_pkg::OFS_ADDR_HIGH) |
                is_reg(a, abu_pkg::OFS_ADDR_LOW) |
                is_reg(a, abu_pkg::OFS_IRQ_STATUS) |
                is_reg(a, abu_pkg::OFS_IRQ_MASK) |
                is_reg(a, abu_pkg::OFS_MONITOR);
    endfunction

    // Writes land at the edge that ends the transfer, never before it.
    assign wr_acc = psel_i & penable_i & pwrite_i & pready_o;
    assign rd_acc = psel_i & penable_i & ~pwrite_i & ~pready_o;
    assign sw_force = wr_acc &
        is_reg(paddr_i, abu_pkg::OFS_CTRL_STATUS) &
        pwdata_i[abu_pkg::BIT_ACTIVE];

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= psel_i & penable_i & ~pready_o;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d = ~known(paddr_i);
        case (1'b1)
            is_reg(paddr_i, abu_pkg::OFS_CTRL_STATUS): begin
                rdata_d[abu_pkg::BIT_ENABLE] = enable_q;
                rdata_d[abu_pkg::BIT_ACTIVE] = active_q;
            end
            is_reg(paddr_i, abu_pkg::OFS_ADDR_HIGH): begin
                rdata_d[7:0] = addr_high_q;
            end
            is_reg(paddr_i, abu_pkg::OFS_ADDR_LOW): begin
                rdata_d[7:0] = addr_low_q;
            end
            is_reg(paddr_i, abu_pkg::OFS_IRQ_STATUS): begin
                rdata_d[abu_pkg::IRQ_W-1:0] = irq_stat_q;
            end
            is_reg(paddr_i, abu_pkg::OFS_IRQ_MASK): begin
                rdata_d[abu_pkg::IRQ_W-1:0] = irq_mask_q;
            end
            is_reg(paddr_i, abu_pkg::OFS_MONITOR): begin
                rdata_d[0] = monitor_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (psel_i & penable_i & ~pready_o) begin
            prdata_o <= rd_acc ? rdata_d : 32'h0000_0000;
            pslverr_o <= err_d;
        end else begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            enable_q <= abu_pkg::RST_CTRL_STATUS[abu_pkg::BIT_ENABLE];
        end else if (wr_acc & is_reg(paddr_i, abu_pkg::OFS_CTRL_STATUS)) begin
            enable_q <= pwdata_i[abu_pkg::BIT_ENABLE];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            addr_high_q <= abu_pkg::RST_ADDR_BYTE;
            addr_low_q <= abu_pkg::RST_ADDR_BYTE;
            monitor_q <= 1'b0;
        end else if (wr_acc) begin
            if (is_reg(paddr_i, abu_pkg::OFS_ADDR_HIGH)) begin
                addr_high_q <= pwdata_i[7:0];
            end
            if (is_reg(paddr_i, abu_pkg::OFS_ADDR_LOW)) begin
                addr_low_q <= pwdata_i[7:0];
            end
            if (is_reg(paddr_i, abu_pkg::OFS_MONITOR)) begin
                monitor_q <= pwdata_i[0];
            end
        end
    end

    // A match sets the flag even in the cycle that software clears it.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            active_q <= 1'b0;
        end else if (hit_ok | sw_force) begin
            active_q <= 1'b1;
        end else if (wr_acc & is_reg(paddr_i, abu_pkg::OFS_CTRL_STATUS)) begin
            active_q <= pwdata_i[abu_pkg::BIT_ACTIVE];
        end
    end

    // ------------------------------------------------------------------
    // Break sequencer
    // ------------------------------------------------------------------
    assign start_now = (hit_ok & enable_q) | sw_force;

    always_comb begin
        state_d = state_q;
        case (state_q)
            abu_pkg::ABU_IDLE: begin
                if (start_now & instr_last_i) begin
                    state_d = abu_pkg::ABU_INJECT;
                end else if (start_now) begin
                    state_d = abu_pkg::ABU_PEND;
                end
            end
            abu_pkg::ABU_PEND: begin
                if (instr_last_i) begin
                    state_d = abu_pkg::ABU_INJECT;
                end
            end
            abu_pkg::ABU_INJECT: begin
                if (vector_taken_i) begin
                    state_d = abu_pkg::ABU_SERVE;
                end
            end
            abu_pkg::ABU_SERVE: begin
                if (~active_q) begin
                    state_d = abu_pkg::ABU_IDLE;
                end
            end
            default: begin
                state_d = abu_pkg::ABU_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_q <= abu_pkg::ABU_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // CPU and peripheral outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            force_opcode_o <= 1'b0;
            opcode_o <= 8'h00;
            vector_o <= abu_pkg::VEC_NORMAL;
        end else begin
            force_opcode_o <= (state_d == abu_pkg::ABU_INJECT);
            opcode_o <= abu_pkg::SWI_OPCODE;
            vector_o <= monitor_q ? abu_pkg::VEC_MONITOR
                                  : abu_pkg::VEC_NORMAL;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            timer_freeze_o <= 1'b0;
            watchdog_disable_o <= 1'b0;
            break_busy_o <= 1'b0;
        end else begin
            timer_freeze_o <= (state_d == abu_pkg::ABU_INJECT) |
                              (state_d == abu_pkg::ABU_SERVE);
            watchdog_disable_o <= test_mode_voltage_i &
                ((state_d == abu_pkg::ABU_INJECT) |
                 (state_d == abu_pkg::ABU_SERVE));
            break_busy_o <= (state_d != abu_pkg::ABU_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, write one to clear; a new event wins
    // ------------------------------------------------------------------
    logic [abu_pkg::IRQ_W-1:0] irq_evt;
    logic [abu_pkg::IRQ_W-1:0] irq_clr;
    assign irq_evt = {(state_q == abu_pkg::ABU_IDLE) &
                      (state_d != abu_pkg::ABU_IDLE), hit_ok};
    assign irq_clr = (wr_acc & is_reg(paddr_i, abu_pkg::OFS_IRQ_STATUS)) ?
                     pwdata_i[abu_pkg::IRQ_W-1:0] : abu_pkg::RST_IRQ;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_stat_q <= abu_pkg::RST_IRQ;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_mask_q <= abu_pkg::RST_IRQ;
        end else if (wr_acc & is_reg(paddr_i, abu_pkg::OFS_IRQ_MASK)) begin
            irq_mask_q <= pwdata_i[abu_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule // abu_top

/* File: verif/abu_cpu_model.sv */
// Behavioural CPU core that walks the bus and accepts forced breaks.
`timescale 1ns/10ps
module abu_cpu_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Bench control
    input wire logic run_i,
    input wire logic [15:0] base_i,
    input wire logic [1:0] ilen_i,
    // Breakpoint unit
    input wire logic force_opcode_i,
    output logic [15:0] addr_o,
    output logic cycle_o,
    output logic last_o,
    output logic taken_o
);
    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    logic [15:0] addr_q;
    logic [1:0] cnt_q, wt_q;
    logic pat_q;
    assign cycle_o = run_i;
    assign last_o = run_i && cnt_q == ilen_i - 2'd1;
    // An idle bus alternates the held address with its inverse each clock.
    assign addr_o = run_i ? addr_q : addr_q ^ {16{pat_q}};
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            {addr_q, cnt_q, wt_q, pat_q, taken_o} <= 22'h0;
        end else begin
            pat_q <= ~pat_q;
            taken_o <= force_opcode_i && wt_q == 2'd2;
            wt_q <= !force_opcode_i ? 2'd0 : wt_q + {1'b0, wt_q != 2'd3};
            if (!run_i) begin
                addr_q <= base_i;
                cnt_q <= 2'd0;
            end else if (!force_opcode_i) begin
                addr_q <= addr_q + 16'h1;
                cnt_q <= last_o ? 2'd0 : cnt_q + 2'd1;
            end
        end
    end
endmodule // abu_cpu_model

/* File: verif/abu_top_assertions.sv */
// Port checker for the breakpoint unit.
`timescale 1ns/10ps
module abu_top_assertions (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    // CPU side
    input wire logic [15:0] cpu_addr_i,
    input wire logic bus_cycle_i,
    input wire logic instr_last_i,
    input wire logic vector_taken_i,
    input wire logic test_mode_voltage_i,
    input wire logic force_opcode_o,
    input wire logic [7:0] opcode_o,
    input wire logic [15:0] vector_o,
    input wire logic timer_freeze_o,
    input wire logic watchdog_disable_o,
    input wire logic break_busy_o
);
    // ------------------------------------------------------------------
    // Shadow of the software view
    // ------------------------------------------------------------------
    logic acc, cs, clr, frc, en_q, mon_q, hit_q;
    logic [7:0] ah_q, al_q;
    assign acc = psel_i && penable_i && pready_o && pwrite_i;
    assign cs = acc && paddr_i == abu_pkg::OFS_CTRL_STATUS;
    assign clr = cs && !pwdata_i[6];
    assign frc = cs && pwdata_i[6];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            {en_q, mon_q, ah_q, al_q} <= 18'h0;
        end else if (acc) begin
            case (paddr_i)
                abu_pkg::OFS_CTRL_STATUS: en_q <= pwdata_i[7];
                abu_pkg::OFS_ADDR_HIGH: ah_q <= pwdata_i[7:0];
                abu_pkg::OFS_ADDR_LOW: al_q <= pwdata_i[7:0];
                abu_pkg::OFS_MONITOR: mon_q <= pwdata_i[0];
                default: ;
            endcase
        end
    end
    // Uses the old compare value, as the design does on a same-edge write.
    always_ff @(posedge ref_clk_i) begin
        hit_q <= bus_cycle_i && cpu_addr_i == {ah_q, al_q};
    end
    a_opcode_forced: assert property (
        force_opcode_o |-> opcode_o == abu_pkg::SWI_OPCODE)
        else $error("forced opcode wrong");
    a_force_held: assert property (
        force_opcode_o && !vector_taken_i |=> force_opcode_o)
        else $error("forced opcode dropped early");
    a_vector_pair: assert property (
        force_opcode_o |-> vector_o ==
        (mon_q ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL))
        else $error("break vector wrong");
    a_start_on_last: assert property (
        $rose(force_opcode_o) |-> $past(instr_last_i))
        else $error("break started mid instruction");
    a_freeze_inject: assert property (
        force_opcode_o |-> timer_freeze_o)
        else $error("timer not frozen");
    a_freeze_held: assert property (
        timer_freeze_o && !clr && !$past(clr) |=> timer_freeze_o)
        else $error("timer released early");
    a_wdog_test: assert property (
        timer_freeze_o && $past(timer_freeze_o) &&
        $past(test_mode_voltage_i) |-> watchdog_disable_o)
        else $error("watchdog not disabled");
    a_wdog_quiet: assert property (
        watchdog_disable_o |-> $past(test_mode_voltage_i) &&
        (timer_freeze_o || $past(timer_freeze_o)))
        else $error("watchdog disabled without cause");
    a_match_breaks: assert property (
        hit_q && en_q && !break_busy_o && !acc |-> ##[1:2] break_busy_o)
        else $error("enabled match gave no break");
    a_no_cause: assert property (
        $rose(break_busy_o) |->
        $past(en_q && hit_q || frc) || $past(en_q && hit_q || frc, 2))
        else $error("break without cause");
    c_break: cover property ($rose(force_opcode_o));
    c_wdog: cover property (watchdog_disable_o);
    c_forced: cover property (frc);
endmodule // abu_top_assertions

bind abu_top abu_top_assertions chk (.ref_clk_i, .sys_rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .cpu_addr_i,
    .bus_cycle_i, .instr_last_i, .vector_taken_i, .test_mode_voltage_i,
    .force_opcode_o, .opcode_o, .vector_o, .timer_freeze_o,
    .watchdog_disable_o, .break_busy_o);

/* File: verif/test_address_breakpoint_unit.sv */
// Self-checking bench for the breakpoint unit.
`timescale 1ns/10ps
module test_address_breakpoint_unit;
    localparam logic [11:0] CS = abu_pkg::OFS_CTRL_STATUS;
    localparam logic [11:0] IS = abu_pkg::OFS_IRQ_STATUS;
    localparam logic [11:0] IM = abu_pkg::OFS_IRQ_MASK;
    logic ref_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o;
    logic pslverr_o, bus_cycle_i, instr_last_i, vector_taken_i, run;
    logic test_mode_voltage_i, force_opcode_o, timer_freeze_o, irq_o;
    logic watchdog_disable_o, break_busy_o, rerr;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rdat;
    logic [15:0] cpu_addr_i, vector_o, base;
    logic [7:0] opcode_o;
    logic [1:0] ilen;
    int fails = 0, n_tests = 0, cyc = 0;
    abu_top uut (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cpu_addr_i,
        .bus_cycle_i, .instr_last_i, .vector_taken_i, .test_mode_voltage_i,
        .force_opcode_o, .opcode_o, .vector_o, .timer_freeze_o,
        .watchdog_disable_o, .break_busy_o, .irq_o);
    abu_cpu_model cpu (.ref_clk_i, .sys_rst_i, .run_i(run), .base_i(base),
        .ilen_i(ilen), .force_opcode_i(force_opcode_o), .addr_o(cpu_addr_i),
        .cycle_o(bus_cycle_i), .last_o(instr_last_i),
        .taken_o(vector_taken_i));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        if (k == 50) begin
            fails++;
            $display("[FAIL] %0t no pready on the bus", $time);
        end
        rdat = prdata_o;
        rerr = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // The model loads its start address while idle, so the base must
    // stand one edge before the run starts.
    task go(input logic [15:0] b, input logic [1:0] l);
        {base, ilen} <= {b, l};
        @(posedge ref_clk_i);
        run <= 1'b1;
    endtask
    // Bounded wait for the forced opcode, then confirm it came.
    task wf;
        int k;
        k = 0;
        while (force_opcode_o !== 1'b1 && k < 100) begin
            @(posedge ref_clk_i);
            k++;
        end
        chk(force_opcode_o, 32'h1);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            $display("[FAIL] %0t run timed out", $time);
            conclude();
        end
    end
    initial begin
        {sys_rst_i, psel_i, penable_i, pwrite_i, paddr_i} <= 16'h8000;
        {pwdata_i, test_mode_voltage_i, run, base, ilen} <= 52'h1;
        wait_cyc(20);
        sys_rst_i <= 1'b0;
        rd(CS, 32'h0);
        chk(vector_o, 32'hFFFC);
        chk(irq_o, 32'h0);
        $display("test reset done");
        wr(abu_pkg::OFS_ADDR_HIGH, 32'h34);
        wr(abu_pkg::OFS_ADDR_LOW, 32'h51);
        rd(abu_pkg::OFS_ADDR_HIGH, 32'h34);
        rd(abu_pkg::OFS_ADDR_LOW, 32'h51);
        wr(IM, 32'h3);
        wr(CS, 32'h80);
        rd(CS, 32'h80);
        test_mode_voltage_i <= 1'b1;
        go(16'h3450, 2'h3);
        wf;
        chk(opcode_o, 32'h83);
        chk(vector_o, 32'hFFFC);
        chk(timer_freeze_o, 32'h1);
        chk(watchdog_disable_o, 32'h1);
        wait_cyc(6);
        run <= 1'b0;
        chk(force_opcode_o, 32'h0);
        chk(timer_freeze_o, 32'h1);
        chk(irq_o, 32'h1);
        rd(CS, 32'hC0);
        wr(CS, 32'h80);
        wait_cyc(3);
        chk(timer_freeze_o, 32'h0);
        chk(break_busy_o, 32'h0);
        rd(IS, 32'h3);
        wr(IS, 32'h3);
        rd(IS, 32'h0);
        chk(irq_o, 32'h0);
        $display("test enabled break done");
        wr(IM, 32'h0);
        wr(CS, 32'h0);
        go(16'h3440, 2'h1);
        wait_cyc(30);
        run <= 1'b0;
        wait_cyc(3);
        chk(break_busy_o, 32'h0);
        chk(irq_o, 32'h0);
        rd(CS, 32'h40);
        rd(IS, 32'h1);
        wr(IS, 32'h1);
        wr(CS, 32'h0);
        rd(CS, 32'h0);
        $display("test disabled match done");
        wr(CS, 32'h80);
        go(16'h3340, 2'h1);
        wait_cyc(30);
        run <= 1'b0;
        wait_cyc(3);
        chk(break_busy_o, 32'h0);
        rd(CS, 32'h80);
        $display("test partial match done");
        wr(abu_pkg::OFS_MONITOR, 32'h1);
        test_mode_voltage_i <= 1'b0;
        go(16'h1000, 2'h1);
        wr(CS, 32'h40);
        wf;
        run <= 1'b0;
        chk(vector_o, 32'hFEFC);
        chk(watchdog_disable_o, 32'h0);
        wait_cyc(6);
        wr(CS, 32'h0);
        wr(abu_pkg::OFS_MONITOR, 32'h0);
        $display("test forced break done");
        apb(1'b0, 12'hFFC, 32'h0);
        chk(rerr, 32'h1);
        chk(rdat, 32'h0);
        $display("test unmapped done");
        conclude();
    end
endmodule // test_address_breakpoint_unit
